// ===== inc/pes_pkg.sv
package pes_pkg;

    // Widths
    localparam int PC_W    = 32;
    localparam int NCOND   = 8;
    localparam int COND_IW = 3;

    // Condition bit positions, lowest index serviced first
    localparam int C_ISI   = 0;
    localparam int C_DSI   = 1;
    localparam int C_ALIGN = 2;
    localparam int C_PROG  = 3;
    localparam int C_FP    = 4;
    localparam int C_TRAP  = 5;
    localparam int C_SC    = 6;
    localparam int C_TRACE = 7;

    // Synchroniser bit positions and idle value
    localparam int P_SOFT = 0;
    localparam int P_HARD = 1;
    localparam int P_TEA  = 2;
    localparam int P_EXT  = 3;
    localparam logic [3:0] SYNC_IDLE = 4'h4;

    // Problem-state bit inside the saved machine state
    localparam int ST_PR_BIT = 14;

    // Instruction size, for the return point
    localparam logic [PC_W-1:0] PC_STEP = 32'h0000_0004;

    // Vector offsets
    localparam logic [PC_W-1:0] VEC_RESET   = 32'h0000_0100;
    localparam logic [PC_W-1:0] VEC_MCHK    = 32'h0000_0200;
    localparam logic [PC_W-1:0] VEC_DSI     = 32'h0000_0300;
    localparam logic [PC_W-1:0] VEC_ISI     = 32'h0000_0400;
    localparam logic [PC_W-1:0] VEC_EXT     = 32'h0000_0500;
    localparam logic [PC_W-1:0] VEC_ALIGN   = 32'h0000_0600;
    localparam logic [PC_W-1:0] VEC_PROG    = 32'h0000_0700;
    localparam logic [PC_W-1:0] VEC_FP      = 32'h0000_0800;
    localparam logic [PC_W-1:0] VEC_DEC     = 32'h0000_0900;
    localparam logic [PC_W-1:0] VEC_SC      = 32'h0000_0c00;
    localparam logic [PC_W-1:0] VEC_RUNMODE = 32'h0000_2000;

    // Vector per condition; trap shares the program vector
    localparam logic [PC_W-1:0] COND_VEC [NCOND] = '{
        VEC_ISI, VEC_DSI, VEC_ALIGN, VEC_PROG,
        VEC_FP, VEC_PROG, VEC_SC, VEC_RUNMODE};

    // Sequencer states, Gray along the loop
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_ENTER   = 2'b01,
        ST_HANDLER = 2'b11,
        ST_RETURN  = 2'b10
    } pes_state_t;

endpackage : pes_pkg

// ===== testbench/pes_pipe_model.sv
`timescale 1ns/10ps
module pes_pipe_model
    import pes_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    // Issue from the bench
    input  wire logic             issue_i,
    input  wire logic [PC_W-1:0]  pc_i,
    input  wire logic [NCOND-1:0] cond_i,
    // Answers from the sequencer
    input  wire logic             retire_i,
    input  wire logic             flush_i,
    // Completion head
    output logic                  head_valid_o,
    output logic [PC_W-1:0]       head_pc_o,
    output logic [NCOND-1:0]      head_cond_o
);
    logic             valid_r; // Head waiting for an answer
    logic [PC_W-1:0]  pc_r;    // Its address
    logic [NCOND-1:0] cond_r;  // Its conditions

    // Head held until retire or flush
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            valid_r <= 1'b0;
        else if (issue_i)
            valid_r <= 1'b1;
        else if (retire_i || flush_i)
            valid_r <= 1'b0;
        if (issue_i)
        begin
            pc_r   <= pc_i;
            cond_r <= cond_i;
        end
    end

    // Head gone in the answer cycle; stale pc shows its inverse, cond shows zero
    assign head_valid_o = valid_r & ~retire_i & ~flush_i;
    assign head_pc_o    = head_valid_o ? pc_r : ~pc_r;
    assign head_cond_o  = head_valid_o ? cond_r : 8'h00;
endmodule : pes_pipe_model

// ===== testbench/precise_exception_sequencer_tb.sv
`timescale 1ns/10ps
module precise_exception_sequencer_tb
    import pes_pkg::*;
;
    logic clk_i, srst_i, sr_i, hr_i, tea_n_i, irq_i, busy_i, dec_i;
    logic ext_en_i, dec_en_i, rfi_i, iss, hv, retire_o, flush_o, hold_o;
    logic redirect_o, supervisor_o, active_o;
    logic [7:0]  cond_en_i, icond, hcond;
    logic [3:0]  exec_i;
    logic [31:0] ipc, hpc, rpc_o, spc_o, sst_o, dfc_o, fsc_o;
    int miscompares, tests_run, cyc;
    // Fixed side inputs
    localparam logic [31:0] NPC = 32'h0000_8000;
    localparam logic [31:0] DFC = 32'h0a00_0000;
    localparam logic [31:0] FPC = 32'h0000_0300;
    localparam logic [31:0] STW = 32'h0000_4000;
    localparam logic [31:0] NOPC = 32'hffff_ffff;

    pes_sequencer u_pes_sequencer (.clk_i(clk_i), .srst_i(srst_i),
        .soft_reset_in_i(sr_i), .hard_reset_in_i(hr_i),
        .transfer_error_ack_in_n_i(tea_n_i), .ext_irq_i(irq_i),
        .data_bus_busy_i(busy_i), .dec_tick_i(dec_i), .ext_en_i(ext_en_i),
        .dec_en_i(dec_en_i), .cond_en_i(cond_en_i), .fsc_clr_i(1'b0),
        .head_valid_i(hv), .head_pc_i(hpc), .head_cond_i(hcond),
        .head_dfc_i(DFC), .head_fpc_i(FPC), .next_pc_i(NPC),
        .exec_count_i(exec_i), .state_i(STW), .rfi_i(rfi_i),
        .retire_o(retire_o), .flush_o(flush_o), .hold_o(hold_o),
        .redirect_o(redirect_o), .redirect_pc_o(rpc_o),
        .supervisor_o(supervisor_o), .handler_active_o(active_o),
        .save_restore_pc_o(spc_o), .save_restore_state_o(sst_o),
        .data_fault_cause_reg_o(dfc_o), .float_status_control_reg_o(fsc_o));

    pes_pipe_model u_pes_pipe_model (.clk_i(clk_i), .srst_i(srst_i),
        .issue_i(iss), .pc_i(ipc), .cond_i(icond), .retire_i(retire_o),
        .flush_i(flush_o), .head_valid_o(hv), .head_pc_o(hpc),
        .head_cond_o(hcond));

    // Free-running clock, 8 ns
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Hang guard, far above the whole sequence
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up

    // Inputs move 1 ns after the rising edge
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Wait for a redirect and judge the entry
    task automatic wait_entry(logic [31:0] vec, logic [31:0] spc);
        int n;
        n = 0;
        while (redirect_o !== 1'b1 && n < 12)
        begin
            tick();
            n++;
        end
        check("redirect", 32'h1, {31'h0, redirect_o});
        check("vector", vec, rpc_o);
        check("supervisor", 32'h1, {31'h0, supervisor_o});
        check("saved state", STW, sst_o);
        if (spc !== NOPC)
            check("saved pc", spc, spc_o);
    endtask : wait_entry

    // Handler return; the entry cycle ignores rfi, so let it pass first
    task automatic do_rfi(logic idle);
        tick();
        rfi_i = 1'b1;
        tick();
        rfi_i = 1'b0;
        tick();
        if (idle)
        begin
            check("active", 32'h0, {31'h0, active_o});
            check("user mode", 32'h0, {31'h0, supervisor_o});
        end
    endtask : do_rfi

    // Present one head and judge the answer
    task automatic run_insn(logic [31:0] pc, logic [7:0] cond,
                            logic rt, logic fl);
        int n;
        iss = 1'b1;
        ipc = pc;
        icond = cond;
        tick();
        iss = 1'b0;
        n = 0;
        while (retire_o !== 1'b1 && flush_o !== 1'b1 && n < 12)
        begin
            tick();
            n++;
        end
        check("retire", {31'h0, rt}, {31'h0, retire_o});
        check("flush", {31'h0, fl}, {31'h0, flush_o});
    endtask : run_insn

    task automatic t_reset_entry();
        wait_entry(VEC_RESET, NOPC);
        do_rfi(1'b1);
    endtask : t_reset_entry

    task automatic t_faults();
        run_insn(32'h0000_1000, 8'h02, 1'b0, 1'b1);
        wait_entry(VEC_DSI, 32'h0000_1000);
        check("data cause", DFC, dfc_o);
        do_rfi(1'b1);
        run_insn(32'h0000_1010, 8'h20, 1'b1, 1'b1);
        wait_entry(VEC_PROG, 32'h0000_1014);
        do_rfi(1'b1);
        run_insn(32'h0000_1020, 8'h80, 1'b1, 1'b1);
        wait_entry(VEC_RUNMODE, 32'h0000_1024);
        do_rfi(1'b1);
        run_insn(32'h0000_1030, 8'h10, 1'b0, 1'b1);
        wait_entry(VEC_FP, 32'h0000_1030);
        check("float status", FPC, fsc_o);
        do_rfi(1'b1);
    endtask : t_faults

    // Two conditions of one instruction, one handler each
    task automatic t_serial();
        run_insn(32'h0000_2000, 8'h05, 1'b0, 1'b1);
        wait_entry(VEC_ISI, 32'h0000_2000);
        check("hold", 32'h1, {31'h0, hold_o});
        do_rfi(1'b0);
        wait_entry(VEC_ALIGN, 32'h0000_2000);
        do_rfi(1'b1);
        check("hold clear", 32'h0, {31'h0, hold_o});
    endtask : t_serial

    task automatic t_disabled();
        cond_en_i = 8'hf7;
        run_insn(32'h0000_3000, 8'h08, 1'b1, 1'b0);
        check("no entry", 32'h0, {31'h0, active_o});
        cond_en_i = 8'hff;
    endtask : t_disabled

    // Masked, then delayed by instructions in execute
    task automatic t_async();
        ext_en_i = 1'b0;
        exec_i = 4'h2;
        irq_i = 1'b1;
        repeat (4) tick();
        irq_i = 1'b0;
        exec_i = 4'h0;
        repeat (6) tick();
        check("masked", 32'h0, {31'h0, active_o});
        ext_en_i = 1'b1;
        run_insn(32'h0000_4000, 8'h00, 1'b1, 1'b0);
        repeat (2) tick();
        check("drain wait", 32'h0, {31'h0, active_o});
        run_insn(32'h0000_4004, 8'h00, 1'b1, 1'b0);
        wait_entry(VEC_EXT, NPC);
        do_rfi(1'b1);
        dec_i = 1'b1;
        tick();
        dec_i = 1'b0;
        wait_entry(VEC_DEC, NPC);
        do_rfi(1'b1);
    endtask : t_async

    // Check from a bus error, then reset pre-empts it
    task automatic t_catastrophic();
        // One-cycle error pulse; a longer one raises repeated checks
        busy_i = 1'b1;
        tea_n_i = 1'b0;
        tick();
        tea_n_i = 1'b1;
        wait_entry(VEC_MCHK, NOPC);
        busy_i = 1'b0;
        sr_i = 1'b1;
        tick();
        wait_entry(VEC_RESET, NOPC);
        sr_i = 1'b0;
        do_rfi(1'b1);
        hr_i = 1'b1;
        tick();
        wait_entry(VEC_RESET, NOPC);
        hr_i = 1'b0;
        do_rfi(1'b1);
    endtask : t_catastrophic

    initial
    begin
        {sr_i, hr_i, irq_i, busy_i, dec_i, rfi_i, iss} = 7'h00;
        {tea_n_i, ext_en_i, dec_en_i, srst_i} = 4'hf;
        cond_en_i = 8'hff;
        exec_i = 4'h0;
        ipc = 32'h0000_0000;
        icond = 8'h00;
        miscompares = 0;
        tests_run = 0;
        cyc = 0;
        repeat (5) tick();
        srst_i = 1'b0;
        t_reset_entry();
        t_faults();
        t_serial();
        t_disabled();
        t_async();
        t_catastrophic();
        wrap_up();
    end
endmodule : precise_exception_sequencer_tb

// ===== verilog/pes_prio_pick.sv
`timescale 1ns/10ps
module pes_prio_pick
    import pes_pkg::*;
#(
    parameter int N  = NCOND,
    parameter int IW = COND_IW
)(
    // Requests
    input  wire logic [N-1:0]  req_i,
    // Lowest request
    output logic               any_o,
    output logic [N-1:0]       onehot_o,
    output logic [IW-1:0]      idx_o
);

    logic [N:0] seen;    // Some lower bit already requested

    assign seen[0] = 1'b0;

    // One grant stage per condition bit
    for (genvar g = 0; g < N; g++)
    begin : g_pick
        assign onehot_o[g] = req_i[g] & ~seen[g];
        assign seen[g+1]   = seen[g] | req_i[g];
    end

    assign any_o = seen[N];

    // Encode the grant
    always_comb
    begin
        idx_o = '0;
        for (int i = 0; i < N; i++)
        begin
            if (onehot_o[i])
                idx_o = IW'(i);
        end
    end

endmodule : pes_prio_pick

// ===== verilog/pes_sequencer.sv
`timescale 1ns/10ps
module pes_sequencer
    import pes_pkg::*;
#(
    parameter int              EXEC_W   = 4,
    parameter logic [PC_W-1:0] VEC_BASE = 32'h0000_0000
)(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              srst_i,
    // Pins from outside the clock domain
    input  wire logic              soft_reset_in_i,
    input  wire logic              hard_reset_in_i,
    input  wire logic              transfer_error_ack_in_n_i,
    input  wire logic              ext_irq_i,
    // Bus and timer events
    input  wire logic              data_bus_busy_i,
    input  wire logic              dec_tick_i,
    // Software enables
    input  wire logic              ext_en_i,
    input  wire logic              dec_en_i,
    input  wire logic [NCOND-1:0]  cond_en_i,
    input  wire logic              fsc_clr_i,
    // Pipeline completion head
    input  wire logic              head_valid_i,
    input  wire logic [PC_W-1:0]   head_pc_i,
    input  wire logic [NCOND-1:0]  head_cond_i,
    input  wire logic [PC_W-1:0]   head_dfc_i,
    input  wire logic [PC_W-1:0]   head_fpc_i,
    input  wire logic [PC_W-1:0]   next_pc_i,
    input  wire logic [EXEC_W-1:0] exec_count_i,
    input  wire logic [PC_W-1:0]   state_i,
    input  wire logic              rfi_i,
    // Answers to the pipeline
    output logic                   retire_o,
    output logic                   flush_o,
    output logic                   hold_o,
    output logic                   redirect_o,
    output logic [PC_W-1:0]        redirect_pc_o,
    // Saved and status state
    output logic                   supervisor_o,
    output logic                   handler_active_o,
    output logic [PC_W-1:0]        save_restore_pc_o,
    output logic [PC_W-1:0]        save_restore_state_o,
    output logic [PC_W-1:0]        data_fault_cause_reg_o,
    output logic [PC_W-1:0]        float_status_control_reg_o
);

    // Synchronisers for the pins
    logic [3:0]        sync_a_r;        // First stage, read only below
    logic [3:0]        sync_b_r;        // Second stage, safe to use
    logic              rst_lvl_r;       // Reset level, one cycle late

    // Pending records
    logic              rst_pend_r;
    logic              mc_pend_r;
    logic              ext_pend_r;
    logic              dec_pend_r;
    logic [EXEC_W-1:0] drain_cnt_r;     // Executing ones still owed

    // Held instruction with conditions left
    logic [NCOND-1:0]  rem_r;
    logic [PC_W-1:0]   rem_pc_r;

    // Sequencer and output registers
    pes_state_t        st_r;
    pes_state_t        st_nxt;
    logic              retire_r;
    logic              flush_r;
    logic              hold_r;
    logic              redirect_r;
    logic [PC_W-1:0]   redirect_pc_r;
    logic              super_r;
    logic              act_r;
    logic [PC_W-1:0]   srr_pc_r;
    logic [PC_W-1:0]   srr_st_r;
    logic [PC_W-1:0]   dfc_r;
    logic [PC_W-1:0]   fsc_r;

    // Picker results
    logic              pick_any;
    logic [NCOND-1:0]  pick_oh;
    logic [COND_IW-1:0] pick_idx;

    // Pin decode
    wire rst_lvl  = sync_b_r[P_SOFT] | sync_b_r[P_HARD];
    wire rst_edge = rst_lvl & ~rst_lvl_r;
    wire tea_hit  = ~sync_b_r[P_TEA] & data_bus_busy_i;
    wire ext_lvl  = sync_b_r[P_EXT];

    // Head acceptance: only the oldest instruction is examined
    wire ans_busy  = retire_r | flush_r;
    wire rem_any   = |rem_r;
    wire head_free = head_valid_i & ~ans_busy & ~rem_any;
    wire [NCOND-1:0] head_en = head_cond_i & cond_en_i;

    // Conditions of the held instruction come before any new one
    wire [NCOND-1:0] src = rem_any ? rem_r :
                           (head_free ? head_en : '0);

    // Priority decode
    wire in_run   = (st_r == ST_RUN);
    wire hi_pend  = rst_pend_r | mc_pend_r;
    wire take_rst = rst_pend_r;
    wire take_mc  = ~rst_pend_r & mc_pend_r;
    wire take_syn = in_run & ~hi_pend & pick_any;
    wire drained  = (drain_cnt_r == '0);
    wire async_ok = in_run & ~hi_pend & ~pick_any & ~ans_busy
                    & drained;
    wire ext_go   = ext_pend_r & ext_en_i;
    wire take_ext = async_ok & ext_go;
    wire take_dec = async_ok & ~ext_go & dec_pend_r & dec_en_i;
    wire take_any = take_rst | take_mc | take_syn | take_ext | take_dec;
    wire from_hd  = take_syn & ~rem_any;

    // Trap, syscall and trace let the instruction finish
    wire completes = pick_oh[C_TRAP] | pick_oh[C_SC]
                     | pick_oh[C_TRACE];

    // A clean head retires unless a reset, check or async entry claims it
    wire retire_nxt = (in_run & ~hi_pend & head_free & ~(|head_en)
                       & ~take_ext & ~take_dec)
                      | (from_hd & completes);

    // Vector selection
    wire [PC_W-1:0] vec_off =
        take_rst ? VEC_RESET :
        take_mc  ? VEC_MCHK  :
        take_syn ? COND_VEC[pick_idx] :
        take_ext ? VEC_EXT : VEC_DEC;

    // Return point
    wire [PC_W-1:0] inst_pc = rem_any ? rem_pc_r : head_pc_i;
    wire [PC_W-1:0] sync_pc = completes ? inst_pc + PC_STEP
                                        : inst_pc;
    wire [PC_W-1:0] asyn_pc = (head_valid_i & ~ans_busy) ? head_pc_i
                                                         : next_pc_i;
    wire [PC_W-1:0] save_pc = take_syn ? sync_pc : asyn_pc;

    // A new async event when none was pending snapshots the drain
    wire async_new = ~(ext_pend_r | dec_pend_r) & (ext_lvl | dec_tick_i);

    // Next values of the records; a set always beats a clear
    wire rst_pend_nxt = rst_edge | (rst_pend_r & ~take_rst);
    wire mc_pend_nxt  = tea_hit | (mc_pend_r & ~take_mc);
    wire ext_pend_nxt = ext_lvl | (ext_pend_r & ~take_ext);
    wire dec_pend_nxt = dec_tick_i | (dec_pend_r & ~take_dec);

    wire [EXEC_W-1:0] drain_nxt =
        async_new ? exec_count_i :
        flush_r   ? '0 :
        (retire_r & ~drained) ? drain_cnt_r - EXEC_W'(1) : drain_cnt_r;

    wire [NCOND-1:0] rem_nxt = (take_rst | take_mc) ? '0 :
                               take_syn ? (src & ~pick_oh) : rem_r;

    // Cause capture for shared vectors
    wire [PC_W-1:0] dfc_nxt = (from_hd & head_en[C_DSI]) ? head_dfc_i
                                                         : dfc_r;
    wire [PC_W-1:0] fsc_nxt =
        (from_hd & head_en[C_FP]) ? (fsc_r | head_fpc_i) :
        fsc_clr_i ? '0 : fsc_r;

    // Supervisor flag restored from saved state on return
    wire super_nxt = take_any ? 1'b1 :
                     (st_r == ST_RETURN) ? ~srr_st_r[ST_PR_BIT] : super_r;

    // Lowest pending condition wins
    pes_prio_pick #(
        .N  (NCOND),
        .IW (COND_IW)
    ) u_pick (
        .req_i    (src),
        .any_o    (pick_any),
        .onehot_o (pick_oh),
        .idx_o    (pick_idx)
    );

    // Sequencer; only reset and check pre-empt a running handler
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ST_RUN:
                if (take_any)
                    st_nxt = ST_ENTER;
            ST_ENTER:
                if (take_rst | take_mc)
                    st_nxt = ST_ENTER;
                else
                    st_nxt = ST_HANDLER;
            ST_HANDLER:
                if (take_rst | take_mc)
                    st_nxt = ST_ENTER;
                else if (rfi_i)
                    st_nxt = ST_RETURN;
            ST_RETURN:
                if (take_rst | take_mc)
                    st_nxt = ST_ENTER;
                else
                    st_nxt = ST_RUN;
        endcase
    end

    // Pin synchronisers; inactive transfer error is high
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            sync_a_r  <= SYNC_IDLE;
            sync_b_r  <= SYNC_IDLE;
            rst_lvl_r <= 1'b0;
        end
        else
        begin
            sync_a_r  <= {ext_irq_i, transfer_error_ack_in_n_i,
                          hard_reset_in_i, soft_reset_in_i};
            sync_b_r  <= sync_a_r;
            rst_lvl_r <= rst_lvl;
        end
    end

    // Pending records; reset release itself raises system reset
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rst_pend_r  <= 1'b1;
            mc_pend_r   <= 1'b0;
            ext_pend_r  <= 1'b0;
            dec_pend_r  <= 1'b0;
            drain_cnt_r <= '0;
        end
        else
        begin
            rst_pend_r  <= rst_pend_nxt;
            mc_pend_r   <= mc_pend_nxt;
            ext_pend_r  <= ext_pend_nxt;
            dec_pend_r  <= dec_pend_nxt;
            drain_cnt_r <= drain_nxt;
        end
    end

    // Held instruction and state
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            st_r     <= ST_RUN;
            rem_r    <= '0;
            rem_pc_r <= '0;
        end
        else
        begin
            st_r     <= st_nxt;
            rem_r    <= rem_nxt;
            rem_pc_r <= from_hd ? sync_pc : rem_pc_r;
        end
    end

    // Pipeline answers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            retire_r      <= 1'b0;
            flush_r       <= 1'b0;
            hold_r        <= 1'b0;
            redirect_r    <= 1'b0;
            redirect_pc_r <= '0;
            act_r         <= 1'b0;
        end
        else
        begin
            retire_r      <= retire_nxt;
            flush_r       <= take_any;
            hold_r        <= |rem_nxt;
            redirect_r    <= take_any;
            redirect_pc_r <= take_any ? (VEC_BASE | vec_off)
                                      : redirect_pc_r;
            act_r         <= (st_nxt != ST_RUN);
        end
    end

    // Saved state and cause registers
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            super_r  <= 1'b1;
            srr_pc_r <= '0;
            srr_st_r <= '0;
            dfc_r    <= '0;
            fsc_r    <= '0;
        end
        else
        begin
            super_r  <= super_nxt;
            srr_pc_r <= take_any ? save_pc : srr_pc_r;
            srr_st_r <= take_any ? state_i : srr_st_r;
            dfc_r    <= dfc_nxt;
            fsc_r    <= fsc_nxt;
        end
    end

    // Outputs straight from registers
    assign retire_o                   = retire_r;
    assign flush_o                    = flush_r;
    assign hold_o                     = hold_r;
    assign redirect_o                 = redirect_r;
    assign redirect_pc_o              = redirect_pc_r;
    assign supervisor_o               = super_r;
    assign handler_active_o           = act_r;
    assign save_restore_pc_o          = srr_pc_r;
    assign save_restore_state_o       = srr_st_r;
    assign data_fault_cause_reg_o     = dfc_r;
    assign float_status_control_reg_o = fsc_r;

    // Checks on the sequencing
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    reset_vector_a: assert property (
        take_rst |=> redirect_o && supervisor_o
                     && redirect_pc_o == (VEC_BASE | VEC_RESET))
        else $error("reset entry not at reset vector");

    check_vector_a: assert property (
        take_mc |=> redirect_o && redirect_pc_o == (VEC_BASE | VEC_MCHK))
        else $error("machine check entry wrong");

    fault_pc_a: assert property (
        (from_hd && !completes)
        |=> flush_o && !retire_o && save_restore_pc_o == $past(head_pc_i))
        else $error("fault did not save its own address");

    trap_return_a: assert property (
        (from_hd && (pick_oh[C_TRAP] || pick_oh[C_SC]))
        |=> retire_o && save_restore_pc_o == $past(head_pc_i) + PC_STEP)
        else $error("trap return point wrong");

    one_handler_a: assert property (
        (st_r == ST_HANDLER && !rst_pend_r && !mc_pend_r)
        |=> !redirect_o)
        else $error("second entry during a handler");

    drain_wait_a: assert property (
        (drain_cnt_r != '0 && !rst_pend_r && !mc_pend_r)
        |=> !(redirect_o && (redirect_pc_o == (VEC_BASE | VEC_EXT)
              || redirect_pc_o == (VEC_BASE | VEC_DEC))))
        else $error("async entry before drain");

    masked_clean_a: assert property (
        (in_run && !hi_pend && head_free && !ext_pend_r && !dec_pend_r
         && (head_cond_i & cond_en_i) == '0)
        |=> retire_o && !flush_o && !redirect_o)
        else $error("disabled condition raised");

    serial_cond_a: assert property (
        (hold_o && in_run && !hi_pend) |=> redirect_o ##1 !retire_o)
        else $error("held condition not taken next");

    trace_vec_a: assert property (
        (take_syn && pick_oh[C_TRACE])
        |=> redirect_pc_o == (VEC_BASE | VEC_RUNMODE))
        else $error("trace not at run-mode vector");

    sync_first_a: assert property (
        (in_run && !hi_pend && pick_any && ext_pend_r && ext_en_i)
        |=> redirect_o && redirect_pc_o != (VEC_BASE | VEC_EXT))
        else $error("async taken before instruction fault");

endmodule : pes_sequencer
